// ===== afecr_pkg.sv
/*
  afecr_pkg: constants for the converter front-end control block.
  assumes: included before afecr_coef_mem.sv and afecr_top.sv.
*/
package afecr_pkg;
  // register offsets of the plain register port
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h2;
  localparam logic [3:0] OFS_ROUTE = 4'h3;
  localparam logic [3:0] OFS_OFFSET = 4'h4;
  localparam logic [3:0] OFS_FULLSCALE = 4'h5;
  localparam logic [3:0] OFS_RESULT = 4'h6;
  // configuration field positions
  localparam int CFG_CHAN_LSB = 0;
  localparam int CFG_PSEUDO_BIT = 8;
  localparam int CFG_BUF_BIT = 9;
  localparam int CFG_GAIN_LSB = 10;
  localparam int CFG_REF_PAIR_SELECT_BIT = 13;
  localparam int CFG_REF_DETECT_EN_BIT = 14;
  localparam int CFG_UNIPOLAR_BIT = 15;
  localparam logic [23:0] CFG_RESET = 24'h000200;
  // status / interrupt bit positions
  localparam int ST_REFMISS_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_RESULT_BIT = 2;
  localparam int ST_CALDONE_BIT = 3;
  localparam int IRQ_BITS = 4;
  // coefficient reset values
  localparam logic [23:0] OFFSET_RESET = 24'h800000;
  localparam logic [23:0] FULLSCALE_RESET = 24'h500000;
  // gain codes and their gains
  localparam logic [2:0] GAIN_CODE_1 = 3'h0;
  localparam logic [2:0] GAIN_CODE_8 = 3'h3;
  localparam logic [2:0] GAIN_CODE_16 = 3'h4;
  localparam logic [2:0] GAIN_CODE_32 = 3'h5;
  localparam logic [2:0] GAIN_CODE_64 = 3'h6;
  localparam logic [2:0] GAIN_CODE_128 = 3'h7;
  localparam logic [7:0] RESULT_MIDSCALE_MSB = 8'h80;
  // common input pin index on the negative mux
  localparam logic [4:0] NEG_COMMON = 5'h10;
endpackage

// ===== afecr_coef_mem.sv
/*
  afecr_coef_mem: two-word calibration coefficient store, registered read.
  assumes: single clock, asynchronous active-high reset; index 0 offset, 1 full scale.
*/
`timescale 1ns/100ps
`default_nettype none
module afecr_coef_mem
  import afecr_pkg::*;
#(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_idx,
  output var logic [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] word;
    logic [WIDTH-1:0] rd;
  } afecr_mem_s;

  afecr_mem_s st_reg;
  afecr_mem_s st_next;

  initial begin
    if (WIDTH != 24) $error("afecr_coef_mem: WIDTH must be 24");
  end

  // write one word, read data registered
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.word[wr_idx] = wr_data;
    end
    st_next.rd = st_reg.word[rd_idx];
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg.word[0] <= OFFSET_RESET;
      st_reg.word[1] <= FULLSCALE_RESET;
      st_reg.rd <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd;
endmodule // afecr_coef_mem
`default_nettype wire

// ===== afecr_top.sv
/*
  afecr_top: front-end control of a 24-bit sigma-delta converter: channel
  routing, buffer, gain, reference choice, polarity, reference detect,
  result clamping and calibration-coefficient guarding.
  assumes: one 250 MHz clock; all inputs synchronous to it; the analog
  comparator delivers the reference level already split into a low and a
  high indication; a host on the plain register port.
*/
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - any of sixteen pins positive or negative
// - routing from channel field and pseudo bit
// - buffer in path when buffer bit set
// - gain 1,8,16,32,64,128 from gain field
// - reference pair chosen by select bit
// - select one turns second pair to reference
// - detection only when detect enable set
// - flag cleared above high threshold
// - flag undefined between thresholds; hold it
// - result all ones while flag active
// - calibration blocked, error set on flag
// - polarity bit picks unipolar or bipolar
// - negative is common or pair member
// - bipolar offset binary, unipolar straight; CONV_RAW coding passed through unchanged
module afecr_top
  import afecr_pkg::*;
#(
  parameter int RES_BITS = 24
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output var logic [23:0] RDATA,
  // reference comparator, modulator results, calibration engine
  input wire logic REF_BELOW_LOW,
  input wire logic REF_ABOVE_HIGH,
  input wire logic CONV_VALID,
  input wire logic [23:0] CONV_RAW,
  input wire logic CAL_DONE,
  input wire logic CAL_IS_FULLSCALE,
  input wire logic [23:0] CAL_COEF,
  // analog switch controls
  output var logic [4:0] MUX_POS,
  output var logic [4:0] MUX_NEG,
  output var logic BUF_ON,
  output var logic [7:0] GAIN_VALUE,
  output var logic REF_PAIR_TWO_SEL,
  output var logic REF_PAIR_TWO_AS_REF,
  output var logic UNIPOLAR,
  output var logic REF_DETECT_ON,
  // result and interrupt
  output var logic RESULT_VALID,
  output var logic [23:0] RESULT,
  output var logic IRQ
);
  typedef struct packed {
    logic [23:0] cfg;
    logic [2:0] gain_code;
    logic ref_missing_flag;
    logic cal_seen_missing;
    logic [IRQ_BITS-1:0] status;
    logic [IRQ_BITS-1:0] mask;
    logic [23:0] result;
    logic result_valid;
    logic [23:0] rdata;
    logic rd_coef;
    logic [4:0] mux_pos;
    logic [4:0] mux_neg;
  } afecr_state_s;

  afecr_state_s st_reg;
  afecr_state_s st_next;
  logic coef_wr;
  logic coef_wr_idx;
  logic [23:0] coef_wr_data;
  logic coef_rd_idx;
  logic [23:0] coef_rd;
  logic [7:0] chan_sel;
  logic pseudo_sel;
  logic [2:0] gain_field;
  logic [23:0] clamp_res;

  initial begin
    if (RES_BITS != 24) $error("afecr_top: RES_BITS must be 24");
  end

  // coefficient store; reads come back registered
  afecr_coef_mem #(.WIDTH(24)) u_coef (
    .clk(CLOCK),
    .rst(RST),
    .wr_en(coef_wr),
    .wr_idx(coef_wr_idx),
    .wr_data(coef_wr_data),
    .rd_idx(coef_rd_idx),
    .rd_data(coef_rd)
  );

  // field views of the configuration register and of the write data (gain field); coefficient read index
  assign chan_sel = st_reg.cfg[CFG_CHAN_LSB +: 8];
  assign pseudo_sel = st_reg.cfg[CFG_PSEUDO_BIT];
  assign gain_field = WDATA[CFG_GAIN_LSB +: 3];
  assign coef_rd_idx = (ADDR == OFS_FULLSCALE);

  // coefficient write: host write, or calibration not spoiled by a missing reference
  always_comb begin
    coef_wr = 1'b0;
    coef_wr_idx = 1'b0;
    coef_wr_data = WDATA;
    if (WR && (ADDR == OFS_OFFSET || ADDR == OFS_FULLSCALE)) begin
      coef_wr = 1'b1;
      coef_wr_idx = (ADDR == OFS_FULLSCALE);
    end else if (CAL_DONE && !st_reg.cal_seen_missing && !st_reg.ref_missing_flag) begin
      coef_wr = 1'b1;
      coef_wr_idx = CAL_IS_FULLSCALE;
      coef_wr_data = CAL_COEF;
    end
  end

  // result path: clamp to all ones while reference missing; coding passes through
  always_comb begin
    clamp_res = CONV_RAW;
    if (st_reg.ref_missing_flag) begin
      clamp_res = '1;
    end
  end

  // next-state logic
  always_comb begin
    logic [IRQ_BITS-1:0] ev;
    ev = '0;
    st_next = st_reg;
    st_next.result_valid = 1'b0;
    st_next.rd_coef = 1'b0;

    // configuration write; gain kept when code is reserved
    if (WR && ADDR == OFS_CONFIG) begin
      st_next.cfg = WDATA;
      unique case (gain_field)
        GAIN_CODE_1, GAIN_CODE_8, GAIN_CODE_16,
        GAIN_CODE_32, GAIN_CODE_64, GAIN_CODE_128: begin
          st_next.gain_code = gain_field;
        end
        default: begin
          st_next.gain_code = st_reg.gain_code;
        end
      endcase
      st_next.cfg[CFG_GAIN_LSB +: 3] = st_next.gain_code;
    end

    // channel routing: field high nibble positive, low nibble negative unless the pseudo bit selects the common pin
    st_next.mux_pos = {1'b0, chan_sel[7:4]};
    if (pseudo_sel) begin
      st_next.mux_neg = NEG_COMMON;
    end else begin
      st_next.mux_neg = {1'b0, chan_sel[3:0]};
    end

    // reference detect; flag held inside the undefined band
    if (st_reg.cfg[CFG_REF_DETECT_EN_BIT]) begin
      if (REF_BELOW_LOW) begin
        st_next.ref_missing_flag = 1'b1;
      end else if (REF_ABOVE_HIGH) begin
        st_next.ref_missing_flag = 1'b0;
      end
    end else begin
      st_next.ref_missing_flag = 1'b0;
    end
    if (st_next.ref_missing_flag && !st_reg.ref_missing_flag) begin
      ev[ST_REFMISS_BIT] = 1'b1;
    end

    // calibration watch: any missing reference during the run spoils it
    if (st_reg.ref_missing_flag) begin
      st_next.cal_seen_missing = 1'b1;
    end
    if (CAL_DONE) begin
      st_next.cal_seen_missing = 1'b0;
      ev[ST_CALDONE_BIT] = 1'b1;
      if (st_reg.cal_seen_missing || st_reg.ref_missing_flag) begin
        ev[ST_ERR_BIT] = 1'b1;
      end
    end

    // conversion result
    if (CONV_VALID) begin
      st_next.result = clamp_res;
      st_next.result_valid = 1'b1;
      ev[ST_RESULT_BIT] = 1'b1;
    end

    // mask write, status write-one-to-clear; a new event wins
    if (WR && ADDR == OFS_IRQ_MASK) begin
      st_next.mask = WDATA[IRQ_BITS-1:0];
    end
    if (WR && ADDR == OFS_STATUS) begin
      st_next.status = st_reg.status & ~WDATA[IRQ_BITS-1:0];
    end
    st_next.status = st_next.status | ev;

    // register reads, data one cycle later
    st_next.rdata = '0;
    if (RD) begin
      unique case (ADDR)
        OFS_CONFIG: st_next.rdata = st_reg.cfg;
        OFS_STATUS: begin
          st_next.rdata[IRQ_BITS-1:0] = st_reg.status;
          st_next.rdata[8] = st_reg.ref_missing_flag;
        end
        OFS_IRQ_MASK: st_next.rdata[IRQ_BITS-1:0] = st_reg.mask;
        OFS_ROUTE: st_next.rdata = {14'h0, st_reg.mux_neg, st_reg.mux_pos};
        OFS_OFFSET, OFS_FULLSCALE: st_next.rd_coef = 1'b1;
        OFS_RESULT: st_next.rdata = st_reg.result;
        default: st_next.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.cfg <= CFG_RESET;
      st_reg.result <= {RESULT_MIDSCALE_MSB, 16'h0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops (coefficient read from the memory register)
  assign RDATA = st_reg.rd_coef ? coef_rd : st_reg.rdata;
  assign MUX_POS = st_reg.mux_pos;
  assign MUX_NEG = st_reg.mux_neg;
  assign BUF_ON = st_reg.cfg[CFG_BUF_BIT];
  assign REF_PAIR_TWO_SEL = st_reg.cfg[CFG_REF_PAIR_SELECT_BIT];
  assign REF_PAIR_TWO_AS_REF = st_reg.cfg[CFG_REF_PAIR_SELECT_BIT];
  assign UNIPOLAR = st_reg.cfg[CFG_UNIPOLAR_BIT];
  assign REF_DETECT_ON = st_reg.cfg[CFG_REF_DETECT_EN_BIT];
  assign RESULT_VALID = st_reg.result_valid;
  assign RESULT = st_reg.result;

  // gain decode from the held code
  always_comb begin
    unique case (st_reg.gain_code)
      GAIN_CODE_8: GAIN_VALUE = 8'd8;
      GAIN_CODE_16: GAIN_VALUE = 8'd16;
      GAIN_CODE_32: GAIN_VALUE = 8'd32;
      GAIN_CODE_64: GAIN_VALUE = 8'd64;
      GAIN_CODE_128: GAIN_VALUE = 8'd128;
      default: GAIN_VALUE = 8'd1;
    endcase
  end

  // interrupt from registered status and mask
  assign IRQ = |(st_reg.status & st_reg.mask);
endmodule // afecr_top
`default_nettype wire

// ===== afecr_top_sva.sv
/* afecr_top_sva: port checks of afecr_top.
   assumes: bound to every afecr_top, single clock. */
`timescale 1ns/100ps
`default_nettype none
module afecr_top_sva
  import afecr_pkg::*;
(
  // clock, reset, inputs
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic REF_BELOW_LOW,
  input wire logic CONV_VALID,
  input wire logic [23:0] CONV_RAW,
  // outputs
  input wire logic [4:0] MUX_POS,
  input wire logic [4:0] MUX_NEG,
  input wire logic BUF_ON,
  input wire logic [7:0] GAIN_VALUE,
  input wire logic REF_PAIR_TWO_SEL,
  input wire logic REF_PAIR_TWO_AS_REF,
  input wire logic UNIPOLAR,
  input wire logic REF_DETECT_ON,
  input wire logic RESULT_VALID,
  input wire logic [23:0] RESULT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // configuration write in this cycle
  logic cw;
  assign cw = WR && ADDR == OFS_CONFIG;
  buf_follows_a: assert property (cw |=> BUF_ON == $past(WDATA[9]))
    else $error("buffer enable wrong");
  det_follows_a: assert property (cw |=> REF_DETECT_ON == $past(WDATA[14]))
    else $error("detect enable wrong");
  polarity_a: assert property (cw |=> UNIPOLAR == $past(WDATA[15]))
    else $error("polarity wrong");
  ref_pins_a: assert property (cw |=> REF_PAIR_TWO_SEL == $past(WDATA[13])
    && REF_PAIR_TWO_AS_REF == REF_PAIR_TWO_SEL) else $error("reference pair wrong");
  mux_route_a: assert property (cw |=> ##1 MUX_POS == {1'b0, $past(WDATA[7:4], 2)}
    && MUX_NEG == ($past(WDATA[8], 2) ? NEG_COMMON : {1'b0, $past(WDATA[3:0], 2)}))
    else $error("routing wrong");
  gain_legal_a: assert property (GAIN_VALUE inside {8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80})
    else $error("gain not supported");
  result_lat_a: assert property (CONV_VALID |=> RESULT_VALID)
    else $error("result missing");
  no_result_a: assert property (!CONV_VALID |=> !RESULT_VALID)
    else $error("result without conversion");
  clamp_ones_a: assert property (REF_DETECT_ON && REF_BELOW_LOW ##1 REF_DETECT_ON && CONV_VALID
    |=> RESULT == 24'hffffff) else $error("result not clamped");
  pass_raw_a: assert property (!REF_DETECT_ON ##1 !REF_DETECT_ON && CONV_VALID
    |=> RESULT == $past(CONV_RAW)) else $error("result altered");
  // main scenarios
  cover property (cw);
  cover property (CONV_VALID && REF_DETECT_ON);
  cover property (RESULT_VALID && RESULT == 24'hffffff);
endmodule // afecr_top_sva
bind afecr_top afecr_top_sva chk (.*);
`default_nettype wire

// ===== afecr_fe_model.sv
/* afecr_fe_model: comparator, modulator and calibration engine.
   assumes: tasks called by the bench right after a clock edge. */
`timescale 1ns/100ps
`default_nettype none
module afecr_fe_model (
  // clock and reference level: 0 low, 1 between, 2 high
  input wire logic clk,
  input wire logic [1:0] ref_lvl,
  // comparator, modulator, calibration
  output wire logic below,
  output wire logic above,
  output var logic cv,
  output var logic [23:0] raw,
  output var logic cd,
  output var logic cfs,
  output var logic [23:0] coef
);
  // the band between thresholds gives neither indication
  assign below = ref_lvl == 2'h0;
  assign above = ref_lvl == 2'h2;
  initial {cv, raw, cd, cfs, coef} = '0;
  // one-cycle result pulse, data scrambled after
  task conv(input logic [23:0] v);
    @(posedge clk);
    cv <= 1'b1;
    raw <= v;
    @(posedge clk);
    cv <= 1'b0;
    raw <= ~v;
  endtask
  // one-cycle calibration finish pulse
  task cal(input logic fs, input logic [23:0] v);
    @(posedge clk);
    cd <= 1'b1;
    cfs <= fs;
    coef <= v;
    @(posedge clk);
    cd <= 1'b0;
    coef <= ~v;
  endtask
endmodule // afecr_fe_model
`default_nettype wire

// ===== afecr_top_tb.sv
/* afecr_top_tb: self-checking bench of afecr_top.
   assumes: afecr_fe_model as analog side, checker bound. */
`timescale 1ns/100ps
`default_nettype none
module afecr_top_tb
  import afecr_pkg::*;
();
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [23:0] WDATA = 24'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [1:0] lvl = 2'h2;
  logic REF_BELOW_LOW, REF_ABOVE_HIGH, CONV_VALID, CAL_DONE, CAL_IS_FULLSCALE;
  logic [23:0] CONV_RAW, CAL_COEF, RDATA, RESULT;
  logic [4:0] MUX_POS, MUX_NEG;
  logic [7:0] GAIN_VALUE;
  logic BUF_ON, REF_PAIR_TWO_SEL, REF_PAIR_TWO_AS_REF, UNIPOLAR, REF_DETECT_ON, RESULT_VALID, IRQ;
  int failures = 0;
  int comparisons = 0;
  logic [23:0] rq[$];
  logic [23:0] cq[$];
  logic rd_p = 1'b0;
  logic [7:0] gtab [8] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  always #2 CLOCK = ~CLOCK;
  afecr_top dut (.*);
  afecr_fe_model fe (.clk(CLOCK), .ref_lvl(lvl), .below(REF_BELOW_LOW),
    .above(REF_ABOVE_HIGH), .cv(CONV_VALID), .raw(CONV_RAW), .cd(CAL_DONE),
    .cfs(CAL_IS_FULLSCALE), .coef(CAL_COEF));
  task chk(input string n, input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // register port cycles
  task wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [23:0] e);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    rq.push_back(e);
    @(posedge CLOCK);
    RD <= 1'b0;
  endtask
  // monitor: read word and result against the oldest note
  always @(posedge CLOCK) begin
    if (rd_p) chk("rdata", RDATA, rq.size() ? rq.pop_front() : 24'hx);
    if (RESULT_VALID === 1'b1) chk("result", RESULT, cq.size() ? cq.pop_front() : 24'hx);
    rd_p = RD;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge CLOCK);
    failures++;
    test_done;
  end
  // main sequence
  initial begin
    logic [23:0] c;
    logic [23:0] v;
    logic [7:0] g;
    logic [2:0] k;
    void'($urandom(32'h9c63aadf));
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    rd(OFS_CONFIG, CFG_RESET);
    rd(OFS_OFFSET, OFFSET_RESET);
    rd(OFS_FULLSCALE, FULLSCALE_RESET);
    rd(4'hf, 24'h0);
    g = 8'h01;
    k = 3'h0;
    // every gain code with random routing and options
    for (int i = 0; i < 16; i++) begin
      c = {8'h00, 16'($urandom())};
      c[12:10] = 3'(i);
      wr(OFS_CONFIG, c);
      // a reserved code leaves the held gain code in the register
      if (|gtab[c[12:10]]) begin
        g = gtab[c[12:10]];
        k = c[12:10];
      end
      c[12:10] = k;
      rd(OFS_CONFIG, c);
      #1;
      chk("gain", GAIN_VALUE, g);
      chk("buffer", BUF_ON, c[9]);
      chk("pos", MUX_POS, c[7:4]);
      chk("neg", MUX_NEG, c[8] ? NEG_COMMON : {1'b0, c[3:0]});
      chk("pair", REF_PAIR_TWO_SEL, c[13]);
      chk("pins", REF_PAIR_TWO_AS_REF, c[13]);
      chk("unipolar", UNIPOLAR, c[15]);
      chk("detect", REF_DETECT_ON, c[14]);
    end
    // reference low, detection off then on
    lvl <= 2'h0;
    wr(OFS_CONFIG, 24'h000200);
    v = 24'($urandom());
    cq.push_back(v);
    fe.conv(v);
    wr(OFS_CONFIG, 24'h004200);
    repeat (2) @(posedge CLOCK);
    cq.push_back(24'hffffff);
    fe.conv(v);
    // calibration without reference: error raised, coefficient kept
    wr(OFS_IRQ_MASK, 24'h000002);
    fe.cal(1'b0, 24'h123456);
    rd(OFS_OFFSET, OFFSET_RESET);
    #1 chk("irq", IRQ, 1'b1);
    wr(OFS_STATUS, 24'h000002);
    @(posedge CLOCK);
    #1 chk("irq", IRQ, 1'b0);
    // middle band, then reference restored
    lvl <= 2'h1;
    repeat (4) @(posedge CLOCK);
    lvl <= 2'h2;
    repeat (2) @(posedge CLOCK);
    cq.push_back(v);
    fe.conv(v);
    // a missing reference since the last finish still spoils this run
    fe.cal(1'b1, ~v);
    rd(OFS_FULLSCALE, FULLSCALE_RESET);
    fe.cal(1'b1, v);
    rd(OFS_FULLSCALE, v);
    repeat (3) @(posedge CLOCK);
    test_done;
  end
endmodule // afecr_top_tb
`default_nettype wire
